// File: hdl/acsi_defines.svh
// Constants of the serial command interface: opcodes, codes, counts.
// Assumes inclusion by bare name from the design files.
`ifndef ACSI_DEFINES_SVH
`define ACSI_DEFINES_SVH

`define ACSI_OP_NOP        8'h00
`define ACSI_OP_WAKE       8'h02
`define ACSI_OP_SLEEP      8'h04
`define ACSI_OP_RESET      8'h06
`define ACSI_OP_START      8'h08
`define ACSI_OP_STOP       8'h0A
`define ACSI_OP_RDATA      8'h12
`define ACSI_OP_SYS_OFS    8'h16
`define ACSI_OP_SYS_GAIN   8'h17
`define ACSI_OP_SELF_OFS   8'h19
`define ACSI_PFX_RD        3'h1
`define ACSI_PFX_WR        3'h2

`define ACSI_CODE_POS_MAX  16'h7FFF
`define ACSI_CODE_NEG_MAX  16'h8000
`define ACSI_RDY_RST       1'b1
`define ACSI_LAST_REG      6'h11

// Times in device clock periods; the device clock is clk_sys_in
`define ACSI_TMO_EXP       15
`define ACSI_TMO_TCLK      (1 << `ACSI_TMO_EXP)
`define ACSI_PRE_TCLK      24
`define ACSI_CMD_DLY_TCLK  2
`define ACSI_TMO_HOLD_CYC  2'h3

`endif

// File: hdl/acsi_pkg.sv
// Types of the serial command interface.
// Assumes nothing of its surroundings.
package acsi_pkg;
  typedef enum logic [4:0] {
    ST_CMD  = 5'b00001,
    ST_RCNT = 5'b00010,
    ST_RDAT = 5'b00100,
    ST_WCNT = 5'b01000,
    ST_WDAT = 5'b10000
  } acsi_state_t;
endpackage

// File: hdl/acsi_link_if.sv
// Signals between the serial-clock side and the device-clock core.
// Assumes the core owns link_rst and tx_byte; the link owns the rest.
`timescale 1ns/1ps
`default_nettype none
interface acsi_link_if;
  logic       link_rst;
  logic [7:0] tx_byte;
  logic [6:0] rx_hi7;
  logic [7:0] rx_byte;
  logic       tgl7;
  logic       tgl8;
  logic       tgl_rise;
  logic       started;
  logic       tx_bit;
  modport link (input link_rst, tx_byte,
                output rx_hi7, rx_byte, tgl7, tgl8, tgl_rise, started, tx_bit);
  modport core (output link_rst, tx_byte,
                input rx_hi7, rx_byte, tgl7, tgl8, tgl_rise, started, tx_bit);
endinterface
`default_nettype wire

// File: hdl/acsi_sync.sv
// Two-flop synchroniser for independent single-bit levels.
// Assumes each bit is a level or a slow toggle from another domain.
`timescale 1ns/1ps
`default_nettype none
module acsi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// File: hdl/acsi_spi_link.sv
// Serial-clock side: byte capture on falling edges, shift-out on rising.
// Assumes sclk idles low outside frames; link_rst is chip select high or the timeout hold.
`timescale 1ns/1ps
`default_nettype none
module acsi_spi_link (
  input  wire logic  sclk_in,
  input  wire logic  rst_n_in,
  input  wire logic  din_in,
  acsi_link_if.link  lk
);
  logic [2:0] rx_cnt;
  logic [6:0] rx_sh;
  logic [2:0] tx_cnt;
  logic [7:0] tx_sh;

  wire [7:0] rx_full = {rx_sh, din_in};

  // Input bits taken on the falling edge only
  always_ff @(negedge sclk_in or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      rx_cnt <= 3'h0;
      rx_sh  <= 7'h00;
    end else begin
      rx_cnt <= rx_cnt + 3'h1;
      rx_sh  <= rx_full[6:0];
    end
  end

  // Toggles survive chip select so the core never sees a false event
  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk.rx_hi7  <= 7'h00;
      lk.rx_byte <= 8'h00;
      lk.tgl7    <= 1'b0;
      lk.tgl8    <= 1'b0;
    end else if (!lk.link_rst) begin
      if (rx_cnt == 3'h6) begin
        lk.rx_hi7 <= rx_full[6:0];
        lk.tgl7   <= ~lk.tgl7;
      end
      if (rx_cnt == 3'h7) begin
        lk.rx_byte <= rx_full;
        lk.tgl8    <= ~lk.tgl8;
      end
    end
  end

  // Output bits change on the rising edge only
  always_ff @(posedge sclk_in or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      tx_cnt     <= 3'h0;
      tx_sh      <= 8'h00;
      lk.started <= 1'b0;
    end else begin
      tx_cnt     <= tx_cnt + 3'h1;
      tx_sh      <= (tx_cnt == 3'h0) ? lk.tx_byte : {tx_sh[6:0], 1'b0};
      lk.started <= 1'b1;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk.tgl_rise <= 1'b0;
    end else if (!lk.link_rst) begin
      lk.tgl_rise <= ~lk.tgl_rise;
    end
  end

  assign lk.tx_bit = (tx_cnt == 3'h1) ? lk.tx_byte[7] : tx_sh[7];
endmodule
`default_nettype wire

// File: hdl/acsi_serial_cmd.sv
// Top of the serial command interface of a delta-sigma converter.
// Assumes conversion results, mode and register file sit outside on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
`include "acsi_defines.svh"

module acsi_serial_cmd #(
  parameter int          RAW_W       = 24,
  parameter int unsigned TIMEOUT_CYC = `ACSI_TMO_TCLK,
  parameter logic [5:0]  LAST_REG    = `ACSI_LAST_REG
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             sclk_in,
  input  wire logic             cs_n_in,
  input  wire logic             din_in,
  output logic                  shared_serial_out_ready_out,
  output logic                  shared_serial_out_ready_oe_out,
  output logic                  conversion_ready_n_out,
  input  wire logic             conv_done_in,
  input  wire logic [RAW_W-1:0] conv_raw_in,
  input  wire logic             continuous_mode_in,
  input  wire logic             timeout_en_in,
  input  wire logic [7:0]       reg_rdata_in,
  output logic      [4:0]       reg_addr_out,
  output logic      [7:0]       reg_wdata_out,
  output logic                  reg_we_out,
  output logic                  wake_cmd_out,
  output logic                  sleep_cmd_out,
  output logic                  reset_cmd_out,
  output logic                  start_cmd_out,
  output logic                  stop_cmd_out,
  output logic                  system_offset_cal_cmd_out,
  output logic                  system_gain_cal_cmd_out,
  output logic                  self_offset_cal_cmd_out,
  output acsi_pkg::acsi_state_t state_out
);
  import acsi_pkg::*;

  function automatic logic [6:0] op_hi(input logic [7:0] op);
    op_hi = op[7:1];
  endfunction

  // Saturate a wide signed result into 16 bits
  function automatic logic [15:0] clip16(input logic [RAW_W-1:0] raw);
    logic signed [RAW_W-1:0] s;
    s = signed'(raw);
    if (s > signed'(RAW_W'(32767)))
      clip16 = `ACSI_CODE_POS_MAX;
    else if (s < -signed'(RAW_W'(32768)))
      clip16 = `ACSI_CODE_NEG_MAX;
    else
      clip16 = raw[15:0];
  endfunction

  acsi_link_if lk ();

  acsi_spi_link u_link (
    .sclk_in  (sclk_in),
    .rst_n_in (rst_n_in),
    .din_in   (din_in),
    .lk       (lk.link)
  );

  logic [3:0]  sync_q;
  logic [2:0]  tgl_prev;
  acsi_state_t state;
  logic [5:0]  ptr;
  logic [4:0]  remain;
  logic [7:0]  tx_byte;
  logic        lo_pend;
  logic [15:0] out_word;
  logic [15:0] result_buf;
  logic [RAW_W-1:0] raw_hold;
  logic [4:0]  pre_cnt;
  logic        rdy_n;
  logic [16:0] tmo_cnt;
  logic [1:0]  tmo_hold;
  logic [1:0]  start_dly;
  logic [1:0]  stop_dly;

  acsi_sync #(.WIDTH(4)) u_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .d_in     ({lk.tgl_rise, lk.tgl8, lk.tgl7, cs_n_in}),
    .q_out    (sync_q)
  );

  wire cs_hi   = sync_q[0];
  wire ev7     = (sync_q[1] ^ tgl_prev[0]) && !cs_hi;
  wire ev8     = (sync_q[2] ^ tgl_prev[1]) && !cs_hi;
  wire ev_rise = (sync_q[3] ^ tgl_prev[2]) && !cs_hi;
  wire [6:0] hi7   = lk.rx_hi7;
  wire [7:0] byte8 = lk.rx_byte;
  wire in_cmd  = (state == ST_CMD);
  wire busy    = !in_cmd;
  wire tmo_hit = timeout_en_in && (tmo_cnt == 17'(TIMEOUT_CYC - 1));
  wire sif_rst = cs_hi || tmo_hit;
  wire rd_ok   = (ptr <= LAST_REG);
  wire [7:0] rd_byte = rd_ok ? reg_rdata_in : 8'h00;

  // Single-byte opcodes, recognised once seven bits are in
  wire c7      = ev7 && in_cmd;
  wire dec_wk  = c7 && (hi7 == op_hi(`ACSI_OP_WAKE));
  wire dec_sl  = c7 && (hi7 == op_hi(`ACSI_OP_SLEEP));
  wire dec_rs  = c7 && (hi7 == op_hi(`ACSI_OP_RESET));
  wire dec_st  = c7 && (hi7 == op_hi(`ACSI_OP_START));
  wire dec_sp  = c7 && (hi7 == op_hi(`ACSI_OP_STOP));
  wire dec_rd  = c7 && (hi7 == op_hi(`ACSI_OP_RDATA));
  // Opcodes whose last bit matters wait for the eighth bit
  wire c8      = ev8 && in_cmd;
  wire dec_so  = c8 && (byte8 == `ACSI_OP_SYS_OFS);
  wire dec_sg  = c8 && (byte8 == `ACSI_OP_SYS_GAIN);
  wire dec_fo  = c8 && (byte8 == `ACSI_OP_SELF_OFS);
  wire dec_rr  = c8 && (byte8[7:5] == `ACSI_PFX_RD);
  wire dec_wr  = c8 && (byte8[7:5] == `ACSI_PFX_WR);
  wire rdy_fall = (pre_cnt == 5'h01);

  // Shared pin shows ready level until the first rising edge of a frame
  assign lk.link_rst = cs_n_in || (tmo_hold != 2'h0);
  assign lk.tx_byte  = tx_byte;
  assign shared_serial_out_ready_out    = lk.started ? lk.tx_bit : rdy_n;
  assign shared_serial_out_ready_oe_out = !cs_n_in;
  assign conversion_ready_n_out         = rdy_n;
  assign start_cmd_out = start_dly[1];
  assign stop_cmd_out  = stop_dly[1];
  assign state_out     = state;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in)
      tgl_prev <= 3'h0;
    else
      tgl_prev <= sync_q[3:1];
  end

  // Timeout: restarts on each byte and whenever deselected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmo_cnt  <= 17'h00000;
      tmo_hold <= 2'h0;
    end else begin
      if (!timeout_en_in || cs_hi || ev8 || tmo_hit)
        tmo_cnt <= 17'h00000;
      else
        tmo_cnt <= tmo_cnt + 17'h00001;
      if (tmo_hit)
        tmo_hold <= `ACSI_TMO_HOLD_CYC;
      else if (tmo_hold != 2'h0)
        tmo_hold <= tmo_hold - 2'h1;
    end
  end

  // Command state; register access blocks further commands
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state  <= ST_CMD;
      ptr    <= 6'h00;
      remain <= 5'h00;
    end else if (sif_rst) begin
      state  <= ST_CMD;
    end else begin
      case (state)
        ST_CMD: begin
          if (dec_rr) begin
            ptr   <= {1'b0, byte8[4:0]};
            state <= ST_RCNT;
          end else if (dec_wr) begin
            ptr   <= {1'b0, byte8[4:0]};
            state <= ST_WCNT;
          end
        end
        ST_RCNT: begin
          if (ev7)
            ptr <= ptr + 6'h01;
          if (ev8) begin
            remain <= byte8[4:0];
            state  <= ST_RDAT;
          end
        end
        ST_RDAT: begin
          if (ev7 && remain != 5'h00 && ptr != 6'h3F)
            ptr <= ptr + 6'h01;
          if (ev8) begin
            if (remain == 5'h00)
              state <= ST_CMD;
            else
              remain <= remain - 5'h01;
          end
        end
        ST_WCNT: begin
          if (ev8) begin
            remain <= byte8[4:0];
            state  <= ST_WDAT;
          end
        end
        ST_WDAT: begin
          if (ev8) begin
            if (ptr != 6'h3F)
              ptr <= ptr + 6'h01;
            if (remain == 5'h00)
              state <= ST_CMD;
            else
              remain <= remain - 5'h01;
          end
        end
        default: state <= ST_CMD;
      endcase
    end
  end

  // Register port; address leads the read data by a whole byte time
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_addr_out  <= 5'h00;
      reg_wdata_out <= 8'h00;
      reg_we_out    <= 1'b0;
    end else begin
      reg_addr_out  <= ptr[4:0];
      reg_we_out    <= 1'b0;
      if (state == ST_WDAT && ev8 && !sif_rst && rd_ok) begin
        reg_wdata_out <= byte8;
        reg_we_out    <= 1'b1;
      end
    end
  end

  // Byte offered for the next shift-out, settled before its first rising edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_byte  <= 8'h00;
      lo_pend  <= 1'b0;
      out_word <= 16'h0000;
    end else if (sif_rst) begin
      tx_byte  <= 8'h00;
      lo_pend  <= 1'b0;
    end else if ((state == ST_RCNT || state == ST_RDAT) && ev7) begin
      if (state == ST_RDAT && remain == 5'h00)
        tx_byte <= 8'h00;
      else
        tx_byte <= rd_byte;
    end else if (in_cmd && rdy_fall) begin
      out_word <= clip16(raw_hold);
      tx_byte  <= 8'(clip16(raw_hold) >> 8);
      lo_pend  <= 1'b1;
    end else if (dec_rd) begin
      out_word <= result_buf;
      tx_byte  <= result_buf[15:8];
      lo_pend  <= 1'b1;
    end else if (c7) begin
      tx_byte  <= lo_pend ? out_word[7:0] : 8'h00;
      lo_pend  <= 1'b0;
    end
  end

  // Ready output: own timing; only its continuous-mode raise on a clock rise needs chip select low
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdy_n      <= `ACSI_RDY_RST;
      pre_cnt    <= 5'h00;
      raw_hold   <= '0;
      result_buf <= 16'h0000;
    end else begin
      if (conv_done_in) begin
        raw_hold <= conv_raw_in;
        pre_cnt  <= 5'(`ACSI_PRE_TCLK);
      end else if (pre_cnt != 5'h00) begin
        pre_cnt <= pre_cnt - 5'h01;
      end
      if (rdy_fall) begin
        rdy_n      <= 1'b0;
        result_buf <= clip16(raw_hold);
      end else if (conv_done_in) begin
        rdy_n <= 1'b1;
      end else if (ev_rise && continuous_mode_in) begin
        rdy_n <= 1'b1;
      end
    end
  end

  // Command strobes; start and stop pass a two-clock delay
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_cmd_out              <= 1'b0;
      sleep_cmd_out             <= 1'b0;
      reset_cmd_out             <= 1'b0;
      system_offset_cal_cmd_out <= 1'b0;
      system_gain_cal_cmd_out   <= 1'b0;
      self_offset_cal_cmd_out   <= 1'b0;
      start_dly                 <= 2'h0;
      stop_dly                  <= 2'h0;
    end else begin
      wake_cmd_out              <= dec_wk && !sif_rst;
      sleep_cmd_out             <= dec_sl && !sif_rst;
      reset_cmd_out             <= dec_rs && !sif_rst;
      system_offset_cal_cmd_out <= dec_so && !sif_rst;
      system_gain_cal_cmd_out   <= dec_sg && !sif_rst;
      self_offset_cal_cmd_out   <= dec_fo && !sif_rst;
      start_dly <= {start_dly[0], dec_st && !sif_rst};
      stop_dly  <= {stop_dly[0], dec_sp && !sif_rst};
    end
  end
endmodule
`default_nettype wire

// File: sim/acsi_serial_cmd_properties.sv
// Checker of the serial command interface, bound to its top.
// Assumes the serial pins are sampled on the device clock.
`timescale 1ns/1ps
`default_nettype none
module acsi_serial_cmd_properties #(
  parameter int unsigned TIMEOUT_CYC = 32768
) (
  input wire logic                  clk_sys_in,
  input wire logic                  rst_n_in,
  input wire logic                  sclk_in,
  input wire logic                  cs_n_in,
  input wire logic                  conv_done_in,
  input wire logic                  continuous_mode_in,
  input wire logic                  timeout_en_in,
  input wire logic                  shared_serial_out_ready_out,
  input wire logic                  shared_serial_out_ready_oe_out,
  input wire logic                  conversion_ready_n_out,
  input wire acsi_pkg::acsi_state_t state_out
);
  import acsi_pkg::*;
  logic        seen_sclk;
  logic [3:0]  low_cnt;
  int unsigned stall_cnt;

  // Pin shows ready only until the frame is clocked
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_sclk <= 1'b0;
      low_cnt   <= 4'h0;
      stall_cnt <= 0;
    end else begin
      seen_sclk <= !cs_n_in && (seen_sclk || sclk_in);
      low_cnt   <= sclk_in ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
      // Loose bound: restarts at clock high, the device only at byte end
      stall_cnt <= (cs_n_in || sclk_in || !timeout_en_in || state_out == ST_CMD) ?
                   0 : stall_cnt + 1;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_ready_held;
    conversion_ready_n_out throughout (##21 1'b1);
  endsequence

  pin_enable_a: assert property (
    shared_serial_out_ready_oe_out == !cs_n_in) else $error("Pin enable wrong");
  deselect_idle_a: assert property (
    cs_n_in [*5] |-> state_out == ST_CMD) else $error("Command state not idle");
  ready_reset_a: assert property (
    disable iff (1'b0) !rst_n_in && $past(!rst_n_in) |-> conversion_ready_n_out)
    else $error("Ready low in reset");
  ready_pulse_a: assert property (
    conv_done_in |=> s_ready_held ##[1:3] !conversion_ready_n_out)
    else $error("Ready pulse timing wrong");
  pin_ready_a: assert property (
    $fell(conversion_ready_n_out) && !cs_n_in && !seen_sclk && !sclk_in
    |-> !shared_serial_out_ready_out) else $error("Pin missed ready fall");
  ready_rise_a: assert property (
    $rose(sclk_in) && !cs_n_in && continuous_mode_in && !conversion_ready_n_out
    |-> ##[1:6] conversion_ready_n_out) else $error("Ready not raised by clock");
  shift_on_rise_a: assert property (
    $changed(shared_serial_out_ready_out) && !cs_n_in && seen_sclk && low_cnt < 4'h8
    |-> sclk_in) else $error("Data changed off rising clock");
  stall_limit_a: assert property (
    stall_cnt <= TIMEOUT_CYC + 16) else $error("Stalled command not reset");
endmodule

bind acsi_serial_cmd acsi_serial_cmd_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_props (
  .clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in),
  .sclk_in(sclk_in),
  .cs_n_in(cs_n_in),
  .conv_done_in(conv_done_in),
  .continuous_mode_in(continuous_mode_in),
  .timeout_en_in(timeout_en_in),
  .shared_serial_out_ready_out(shared_serial_out_ready_out),
  .shared_serial_out_ready_oe_out(shared_serial_out_ready_oe_out),
  .conversion_ready_n_out(conversion_ready_n_out),
  .state_out(state_out)
);
`default_nettype wire

// File: sim/acsi_host_model.sv
// Host controller model: mode 1 frames on an 80 ns serial clock.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module acsi_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in
);
  initial begin
    sclk_out = 1'b0; // Clock idles low between frames
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end

  // Select only moves with the clock idle; odd delay keeps phase apart
  task automatic select(input logic on);
    #13;
    cs_n_out = !on;
    #50;
  endtask

  // MSB first; data moves on the rise, sampled on the fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_out = 1'b1;
      din_out  = tx[i];
      #40;
      rx[i]    = dout_in;
      sclk_out = 1'b0;
      #40;
    end
    din_out = 1'b0; // Low while only reading
  endtask
endmodule
`default_nettype wire

// File: sim/acsi_serial_cmd_tb_top.sv
// Bench of the serial command interface; host model on the serial side.
// Assumes a stand-in register file answering {~address[2:0], address}.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module acsi_serial_cmd_tb_top;
  import acsi_pkg::*;
  localparam logic [7:0] OPS [16] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0A, 8'h0B, 8'h12, 8'h13, 8'h16, 8'h17, 8'h19};
  // Strobe bits: wake sleep reset start stop sys-offset sys-gain self-offset
  localparam logic [7:0] STB [16] = '{8'h00, 8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20,
    8'h10, 8'h10, 8'h08, 8'h08, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01};
  localparam logic [23:0] RAW [6] = '{24'h7FFFFF, 24'h008000, 24'h007FFF, 24'hFFFFFF,
    24'hFF8000, 24'hFF7FFF};
  localparam logic [15:0] CODE [6] = '{16'h7FFF, 16'h7FFF, 16'h7FFF, 16'hFFFF,
    16'h8000, 16'h8000};
  localparam logic [7:0] WR [5] = '{8'h50, 8'h02, 8'h11, 8'h22, 8'h33};
  logic        clk_sys = 1'b0;
  logic        rst_n;
  logic        conv_done;
  logic        cont_mode;
  logic        tmo_en;
  logic [23:0] conv_raw;
  logic        seen_clr;
  logic [7:0]  seen = 8'h00;
  logic [7:0]  rx;
  logic [12:0] wq [$];
  int          err_total = 0;
  int          checks = 0;
  wire         sclk, cs_n, din, dout, dout_oe, rdy_n, we;
  wire         stb_wk, stb_sl, stb_rs, stb_st, stb_sp, stb_so, stb_sg, stb_fo;
  wire [4:0]   raddr;
  wire [7:0]   wdata, rdata;
  wire [7:0]   strb = {stb_wk, stb_sl, stb_rs, stb_st, stb_sp, stb_so, stb_sg, stb_fo};
  acsi_state_t st;
  wire         dout_pin = dout_oe ? dout : 1'bz;

  assign rdata = {~raddr[2:0], raddr};
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    seen <= seen_clr ? 8'h00 : (seen | strb);
    if (we)
      wq.push_back({raddr, wdata});
  end

  acsi_serial_cmd #(.TIMEOUT_CYC(256)) i_dut (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
    .shared_serial_out_ready_out(dout), .shared_serial_out_ready_oe_out(dout_oe),
    .conversion_ready_n_out(rdy_n), .conv_done_in(conv_done), .conv_raw_in(conv_raw),
    .continuous_mode_in(cont_mode), .timeout_en_in(tmo_en), .reg_rdata_in(rdata),
    .reg_addr_out(raddr), .reg_wdata_out(wdata), .reg_we_out(we),
    .wake_cmd_out(stb_wk), .sleep_cmd_out(stb_sl), .reset_cmd_out(stb_rs),
    .start_cmd_out(stb_st), .stop_cmd_out(stb_sp), .system_offset_cal_cmd_out(stb_so),
    .system_gain_cal_cmd_out(stb_sg), .self_offset_cal_cmd_out(stb_fo), .state_out(st));
  acsi_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout_pin));

  task automatic clks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic pulse(input logic [23:0] raw);
    @(negedge clk_sys);
    conv_raw  = raw;
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
  endtask

  task automatic rd16(output logic [15:0] v);
    i_host.xfer(8'h00, v[15:8]);
    i_host.xfer(8'h00, v[7:0]);
  endtask

  task automatic t_ctrl();
    for (int i = 0; i < 16; i++) begin
      seen_clr = 1'b1;
      clks(1);
      seen_clr = 1'b0;
      i_host.select(1'b1);
      i_host.xfer(OPS[i], rx); // Defined opcodes plus their last-bit-set variants
      i_host.select(1'b0);
      clks(8);
      `CHK("strobes", STB[i], seen)
    end
  endtask

  task automatic t_result();
    logic [15:0] v;
    for (int i = 0; i < 6; i++) begin
      i_host.select(1'b1);
      pulse(RAW[i]);
      `CHK("ready high", 1'b1, rdy_n)
      clks(26);
      `CHK("ready low", 1'b0, rdy_n)
      `CHK("pin ready", 1'b0, dout_pin)
      rd16(v);
      `CHK("result", CODE[i], v)
      `CHK("ready back", 1'b1, rdy_n)
      i_host.select(1'b0);
    end
  endtask

  // Unread results while deselected, then a register read that must not be disturbed
  task automatic t_keep();
    logic [15:0] v;
    clks(1);
    cont_mode = 1'b0;
    pulse(24'h001234);
    clks(26);
    `CHK("ready deselected", 1'b0, rdy_n)
    pulse(24'hFFEDCC);
    clks(26);
    i_host.select(1'b1);
    i_host.xfer(8'h12, rx);
    rd16(v);
    `CHK("newest result", 16'hEDCC, v)
    i_host.xfer(8'h30, rx);
    pulse(24'h000042);
    i_host.xfer(8'h03, rx);
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(8'h00, rx);
      `CHK("register byte", (i < 2) ? {~3'(i), 5'h10 + 5'(i)} : 8'h00, rx)
    end
    i_host.xfer(8'h12, rx);
    rd16(v);
    `CHK("kept result", 16'h0042, v)
    i_host.select(1'b0);
  endtask

  // Long enough to outlast the timeout unless each byte restarts it
  task automatic t_write();
    i_host.select(1'b1);
    for (int i = 0; i < 5; i++)
      i_host.xfer(WR[i], rx);
    i_host.select(1'b0);
    clks(4);
    `CHK("write count", 2, wq.size())
    `CHK("write first", {5'h10, 8'h11}, wq[0])
    `CHK("write second", {5'h11, 8'h22}, wq[1])
  endtask

  task automatic t_stall();
    i_host.select(1'b1);
    i_host.xfer(8'h25, rx);
    clks(6);
    `CHK("state address", ST_RCNT, st)
    i_host.select(1'b0);
    clks(2);
    `CHK("pin released", 1'b0, dout_oe)
    `CHK("state abort", ST_CMD, st)
    tmo_en = 1'b0;
    i_host.select(1'b1);
    i_host.xfer(8'h45, rx);
    clks(300);
    `CHK("no timeout", ST_WCNT, st)
    tmo_en = 1'b1;
    clks(300);
    `CHK("timeout", ST_CMD, st)
    i_host.select(1'b0);
  endtask

  task automatic close_out();
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    rst_n     = 1'b0;
    conv_done = 1'b0;
    cont_mode = 1'b1;
    tmo_en    = 1'b1;
    conv_raw  = 24'h000000;
    seen_clr  = 1'b0;
    clks(4);
    `CHK("ready at power-on", 1'b1, rdy_n)
    rst_n = 1'b1;
    clks(4);
    t_ctrl();
    t_result();
    t_keep();
    t_write();
    t_stall();
    close_out();
  end

  // Whole run needs well under 100 us
  initial begin
    #200000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
